// file: hdl/hostport_pkg.sv
// shared constants for the generic host bus port
package hostport_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int EV_W   = 3;
   // device register indices
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h1;
   localparam logic [3:0] REG_MASK = 4'h2;
   localparam logic [3:0] REG_DMA  = 4'h3;
   // device control fields
   localparam int CTRL_DMA_EN    = 0;
   localparam int CTRL_TO_HOST   = 1;
   localparam int CTRL_EOP_HIGH  = 2;
   localparam int CTRL_BYTE_MODE = 5;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   // device event bits
   localparam int EV_EOP  = 0;
   localparam int EV_RX   = 1;
   localparam int EV_USER = 2;
   // host controller register indices
   localparam logic [2:0] HREG_CMD   = 3'h0;
   localparam logic [2:0] HREG_WDATA = 3'h1;
   localparam logic [2:0] HREG_RDATA = 3'h2;
   localparam logic [2:0] HREG_STAT  = 3'h3;
   localparam logic [2:0] HREG_MASK  = 3'h4;
   localparam logic [2:0] HREG_CFG   = 3'h5;
   // host command fields
   localparam int CMD_WRITE  = 4;
   localparam int CMD_DMA    = 5;
   localparam int CMD_HBE_N  = 6;
   localparam int CMD_LAST   = 7;
   // host config fields
   localparam int CFG_RDY_HIGH = 0;
   localparam int CFG_EOP_HIGH = 1;
   localparam int CFG_HW_RST   = 2;
   localparam logic [2:0] CFG_RESET = 3'h1;
   // host event bits
   localparam int HEV_DONE = 0;
   localparam int HEV_REQ  = 1;
   localparam int HEV_DINT = 2;
   typedef enum logic [1:0] {
      CYC_IDLE    = 2'b00,
      CYC_SETUP   = 2'b01,
      CYC_STROBE  = 2'b11,
      CYC_RELEASE = 2'b10
   } cycle_state_t;
endpackage

// file: hdl/hostport_if.sv
// system bus wires between host controller and device
`timescale 1ns/1ns
`default_nettype none
interface hostport_if;
   logic [3:0]  system_address_lines;
   logic        chip_select_n;
   logic        read_strobe_n;
   logic        write_strobe_n;
   logic        high_byte_enable_n;
   logic        dma_acknowledge_n;
   logic        dma_end_of_process;
   logic        hardware_reset_in;
   logic [15:0] host_data;
   logic        host_data_oe;
   logic [15:0] dev_data;
   logic        dev_data_oe;
   logic [15:0] system_data_lines;
   logic        dma_request;
   logic        ready;
   logic        bus_width_indicator;
   logic        interrupt_n;
   // wire level from the enables; floating bus reads high
   assign system_data_lines = dev_data_oe  ? dev_data  :
                              host_data_oe ? host_data : 16'hffff;
   modport device (
      input  system_address_lines, chip_select_n, read_strobe_n,
      input  write_strobe_n, high_byte_enable_n, dma_acknowledge_n,
      input  dma_end_of_process, hardware_reset_in, system_data_lines,
      output dev_data, dev_data_oe, dma_request, ready,
      output bus_width_indicator, interrupt_n
   );
   modport host (
      output system_address_lines, chip_select_n, read_strobe_n,
      output write_strobe_n, high_byte_enable_n, dma_acknowledge_n,
      output dma_end_of_process, hardware_reset_in, host_data,
      output host_data_oe,
      input  system_data_lines, dma_request, ready,
      input  bus_width_indicator, interrupt_n
   );
endinterface
`default_nettype wire

// file: hdl/lane_steer.sv
// byte lane decode from width, high byte enable and address bit 0
`timescale 1ns/1ns
`default_nettype none
module lane_steer (
   input  wire logic i_byte_mode,
   input  wire logic i_high_byte_enable_n,
   input  wire logic i_addr0,
   output logic      o_lo_en,
   output logic      o_hi_en
);
   always_comb begin
      if (i_byte_mode) begin
         o_lo_en = 1'b1;
         o_hi_en = 1'b0;
      end else begin
         // 1,1 is unused: neither lane moves
         o_lo_en = ~i_addr0;
         o_hi_en = ~i_high_byte_enable_n;
      end
   end
endmodule
`default_nettype wire

// file: hdl/hostport_device.sv
// device end of the generic microprocessor bus port
// Function
// - 8-bit mode: only low lane carries data
// - 16-bit mode: enable and A0 pick lanes
// - host drives high byte enable low
// - dma data shares the system data bus
// - end of process stops dma requests
// - end of process polarity is selectable
// - dma request is active high
// - dma acknowledge from controller is low
// - ready polarity follows the select input
// - width indicator is inverse of width bit
// - mode select enables the generic bus
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module hostport_device (
   input  wire logic        i_core_clk,
   input  wire logic        i_sys_rst,
   hostport_if.device       bus,
   input  wire logic        i_generic_bus_mode_select,
   input  wire logic        i_ready_polarity_select,
   input  wire logic        i_rx_valid,
   input  wire logic [hostport_pkg::DATA_W-1:0] i_rx_data,
   output logic             o_rx_ready,
   output logic             o_tx_valid,
   output logic [hostport_pkg::DATA_W-1:0] o_tx_data,
   input  wire logic        i_event
);
   import hostport_pkg::*;

   logic [15:0]     ctrl;
   logic [EV_W-1:0] status;
   logic [EV_W-1:0] mask;
   logic            busy;
   logic            hi_phase;
   logic            rx_valid_d;
   logic [7:0]      tx_low;
   logic            lo_en;
   logic            hi_en;

   wire logic hw_rst  = bus.hardware_reset_in;
   wire logic rd      = ~bus.read_strobe_n;
   wire logic wr      = ~bus.write_strobe_n;
   wire logic reg_sel = i_generic_bus_mode_select
                        & ~bus.chip_select_n;
   wire logic dma_sel = i_generic_bus_mode_select
                        & ~bus.dma_acknowledge_n;
   wire logic active  = (reg_sel | dma_sel) & (rd | wr);
   wire logic start   = active & ~busy;
   wire logic byte_md = ctrl[CTRL_BYTE_MODE];
   wire logic dma_on  = ctrl[CTRL_DMA_EN];
   wire logic to_host = ctrl[CTRL_TO_HOST];
   wire logic eop_seen = i_generic_bus_mode_select & dma_on
      & (bus.dma_end_of_process == ctrl[CTRL_EOP_HIGH]);
   // registers win over dma if both selects are low
   wire logic dma_go  = start & dma_sel & ~reg_sel & dma_on;
   wire logic reg_go  = start & reg_sel;
   wire logic [3:0] addr = bus.system_address_lines;
   wire logic [15:0] din = bus.system_data_lines;
   // byte mode moves a dma word in two strobes, low byte first
   wire logic word_done = ~byte_md | hi_phase;

   lane_steer u_lane (
      .i_byte_mode          (byte_md),
      .i_high_byte_enable_n (bus.high_byte_enable_n),
      .i_addr0              (addr[0]),
      .o_lo_en              (lo_en),
      .o_hi_en              (hi_en)
   );

   // access tracking: one access per strobe, until released
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         busy <= 1'b0;
      end else if (hw_rst) begin
         busy <= 1'b0;
      end else begin
         busy <= active;
      end
   end

   // control register; end of process clears the dma enable
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl <= CTRL_RESET;
      end else if (hw_rst) begin
         ctrl <= CTRL_RESET;
      end else begin
         if (reg_go && wr && addr == REG_CTRL) begin
            if (lo_en) begin
               ctrl[7:0] <= din[7:0];
            end
            if (hi_en) begin
               ctrl[15:8] <= din[15:8];
            end
         end
         if (eop_seen) begin
            ctrl[CTRL_DMA_EN] <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mask <= '0;
      end else if (hw_rst) begin
         mask <= '0;
      end else if (reg_go && wr && addr == REG_MASK && lo_en) begin
         mask <= din[EV_W-1:0];
      end
   end

   // sticky events; a read clears, a new event in that cycle wins
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         status     <= '0;
         rx_valid_d <= 1'b0;
      end else if (hw_rst) begin
         status     <= '0;
         rx_valid_d <= 1'b0;
      end else begin
         rx_valid_d <= i_rx_valid;
         status <= ((reg_go && rd && addr == REG_STAT) ? '0 : status)
                   | {i_event, i_rx_valid & ~rx_valid_d, eop_seen};
      end
   end

   // read data and bus drive
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bus.dev_data    <= 16'h0000;
         bus.dev_data_oe <= 1'b0;
      end else if (hw_rst || !active) begin
         bus.dev_data_oe <= 1'b0;
      end else if (start && rd && (reg_go || dma_go)) begin
         bus.dev_data_oe <= 1'b1;
         if (dma_go) begin
            // dma reads share the register data bus
            if (!byte_md) begin
               bus.dev_data <= i_rx_data;
            end else begin
               bus.dev_data <= {8'h00, hi_phase ? i_rx_data[15:8]
                                               : i_rx_data[7:0]};
            end
         end else begin
            unique case (addr)
               REG_CTRL: bus.dev_data <= ctrl;
               REG_STAT: bus.dev_data <= {13'h0000, status};
               REG_MASK: bus.dev_data <= {13'h0000, mask};
               REG_DMA:  bus.dev_data <= i_rx_data;
               default:  bus.dev_data <= 16'h0000;
            endcase
            if (byte_md) begin
               bus.dev_data[15:8] <= 8'h00;
            end
         end
      end
   end

   // dma word assembly and hand-off to the buffer side
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         hi_phase   <= 1'b0;
         tx_low     <= 8'h00;
         o_tx_data  <= 16'h0000;
         o_tx_valid <= 1'b0;
         o_rx_ready <= 1'b0;
      end else if (hw_rst) begin
         hi_phase   <= 1'b0;
         o_tx_valid <= 1'b0;
         o_rx_ready <= 1'b0;
      end else begin
         o_tx_valid <= 1'b0;
         o_rx_ready <= 1'b0;
         if (eop_seen || !byte_md) begin
            hi_phase <= 1'b0;
         end
         if (dma_go && (rd == to_host)) begin
            if (byte_md) begin
               hi_phase <= ~hi_phase;
            end
            if (rd) begin
               o_rx_ready <= word_done;
            end else if (!word_done) begin
               tx_low <= din[7:0];
            end else begin
               o_tx_valid <= 1'b1;
               o_tx_data  <= byte_md ? {din[7:0], tx_low} : din;
            end
         end
      end
   end

   // pin outputs
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bus.dma_request         <= 1'b0;
         bus.ready               <= 1'b0;
         bus.bus_width_indicator <= 1'b1;
         bus.interrupt_n         <= 1'b1;
      end else if (hw_rst) begin
         bus.dma_request         <= 1'b0;
         bus.ready               <= ~i_ready_polarity_select;
         bus.bus_width_indicator <= 1'b1;
         bus.interrupt_n         <= 1'b1;
      end else begin
         // request drops while a strobe is open so one ask is one move
         bus.dma_request <= i_generic_bus_mode_select & dma_on
            & ~eop_seen & ~active & ~busy
            & (i_rx_valid | ~to_host);
         bus.ready <= (active & (reg_sel | dma_on))
            ? i_ready_polarity_select
            : ~i_ready_polarity_select;
         bus.bus_width_indicator <= ~byte_md;
         bus.interrupt_n <= ~|(status & mask);
      end
   end
endmodule
`default_nettype wire

// file: hdl/hostport_host.sv
// host end: bus cycle sequencer driven from a small register port
`timescale 1ns/1ns
`default_nettype none
module hostport_host (
   input  wire logic        i_core_clk,
   input  wire logic        i_sys_rst,
   hostport_if.host         bus,
   input  wire logic [2:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [15:0]      o_rdata,
   output logic             o_irq
);
   import hostport_pkg::*;

   cycle_state_t    state;
   logic [7:0]      cmd;
   logic [15:0]     wdata;
   logic [15:0]     rdata;
   logic [2:0]      cfg;
   logic [EV_W-1:0] status;
   logic [EV_W-1:0] mask;
   logic            req_d;

   wire logic go = i_wr && i_addr == HREG_CMD && state == CYC_IDLE;
   wire logic rdy = bus.ready == cfg[CFG_RDY_HIGH];
   wire logic done = state == CYC_RELEASE;

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cmd   <= 8'h00;
         wdata <= 16'h0000;
         cfg   <= CFG_RESET;
         mask  <= '0;
      end else if (i_wr) begin
         unique case (i_addr)
            HREG_CMD:   cmd   <= (state == CYC_IDLE) ? i_wdata[7:0] : cmd;
            HREG_WDATA: wdata <= i_wdata;
            HREG_MASK:  mask  <= i_wdata[EV_W-1:0];
            HREG_CFG:   cfg   <= i_wdata[2:0];
            default:    cfg   <= cfg;
         endcase
      end
   end

   // cycle sequencer; no timeout, a silent device stalls it
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state <= CYC_IDLE;
         rdata <= 16'h0000;
      end else begin
         unique case (state)
            CYC_IDLE:    state <= go ? CYC_SETUP : CYC_IDLE;
            CYC_SETUP:   state <= CYC_STROBE;
            CYC_STROBE: begin
               if (rdy) begin
                  state <= CYC_RELEASE;
                  if (!cmd[CMD_WRITE]) begin
                     rdata <= bus.system_data_lines;
                  end
               end
            end
            CYC_RELEASE: state <= CYC_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bus.system_address_lines <= 4'h0;
         bus.chip_select_n        <= 1'b1;
         bus.read_strobe_n        <= 1'b1;
         bus.write_strobe_n       <= 1'b1;
         bus.high_byte_enable_n   <= 1'b1;
         bus.dma_acknowledge_n    <= 1'b1;
         bus.dma_end_of_process   <= 1'b0;
         bus.hardware_reset_in    <= 1'b0;
         bus.host_data            <= 16'h0000;
         bus.host_data_oe         <= 1'b0;
      end else begin
         bus.hardware_reset_in <= cfg[CFG_HW_RST];
         bus.dma_end_of_process <= (done & cmd[CMD_DMA] & cmd[CMD_LAST])
            ? cfg[CFG_EOP_HIGH] : ~cfg[CFG_EOP_HIGH];
         if (go) begin
            bus.system_address_lines <= i_wdata[3:0];
            bus.high_byte_enable_n <= i_wdata[CMD_HBE_N];
            bus.chip_select_n <= i_wdata[CMD_DMA];
            bus.dma_acknowledge_n <= ~i_wdata[CMD_DMA];
            bus.host_data    <= wdata;
            bus.host_data_oe <= i_wdata[CMD_WRITE];
         end else if (state == CYC_SETUP) begin
            bus.read_strobe_n  <= cmd[CMD_WRITE];
            bus.write_strobe_n <= ~cmd[CMD_WRITE];
         end else if (state == CYC_STROBE && rdy) begin
            bus.read_strobe_n     <= 1'b1;
            bus.write_strobe_n    <= 1'b1;
            bus.chip_select_n     <= 1'b1;
            bus.dma_acknowledge_n <= 1'b1;
            bus.high_byte_enable_n <= 1'b1;
            bus.host_data_oe      <= 1'b0;
         end
      end
   end

   // sticky events, cleared by a read of the status register
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         status <= '0;
         req_d  <= 1'b0;
         o_irq  <= 1'b0;
      end else begin
         req_d  <= bus.dma_request;
         status <= ((i_rd && i_addr == HREG_STAT) ? '0 : status)
                   | {~bus.interrupt_n, bus.dma_request & ~req_d, done};
         o_irq  <= |(status & mask);
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         unique case (i_addr)
            HREG_CMD:   o_rdata <= {8'h00, cmd};
            HREG_WDATA: o_rdata <= wdata;
            HREG_RDATA: o_rdata <= rdata;
            HREG_STAT:  o_rdata <= {state != CYC_IDLE, 12'h000, status};
            HREG_MASK:  o_rdata <= {13'h0000, mask};
            HREG_CFG:   o_rdata <= {13'h0000, cfg};
            default:    o_rdata <= 16'h0000;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: tb/hostport_asserts.sv
// concurrent checks on the wires between host and device ends
`timescale 1ns/1ns
`default_nettype none
module hostport_asserts (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_generic_bus_mode_select,
   input wire logic i_ready_polarity_select,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic dma_acknowledge_n,
   input wire logic dma_end_of_process,
   input wire logic hardware_reset_in,
   input wire logic host_data_oe,
   input wire logic dev_data_oe,
   input wire logic dma_request,
   input wire logic ready,
   input wire logic bus_width_indicator
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_sys_rst);

   // system reset leaves ready low, hardware reset leaves it inactive; skip the edge after any reset or flip
   a_ready_cause: assert property (
      ready == i_ready_polarity_select && !$past(i_sys_rst)
      && !$past(hardware_reset_in) && $stable(i_ready_polarity_select)
      |-> $past(!read_strobe_n || !write_strobe_n))
      else $error("ready active without a strobe");
   a_ready_answer: assert property (
      $fell(read_strobe_n && write_strobe_n) && i_generic_bus_mode_select
      && (!chip_select_n || !dma_acknowledge_n)
      |-> ##[1:3] ready == i_ready_polarity_select)
      else $error("selected strobe got no ready");
   a_mode_off_quiet: assert property (
      !i_generic_bus_mode_select && !$past(i_generic_bus_mode_select)
      && $stable(i_ready_polarity_select) && !$past(hardware_reset_in)
      |-> ready != i_ready_polarity_select)
      else $error("ready active with bus mode off");
   a_eop_stops_req: assert property (
      $changed(dma_end_of_process) ##1 $changed(dma_end_of_process)
      |-> !dma_request [*4])
      else $error("dma request after end of process");
   a_req_mode: assert property (
      dma_request |-> $past(i_generic_bus_mode_select))
      else $error("dma request with bus mode off");
   a_req_no_strobe: assert property (
      dma_request |-> $past(read_strobe_n && write_strobe_n))
      else $error("dma request during a strobe");
   a_oe_read_only: assert property (
      dev_data_oe |-> $past(!read_strobe_n) && write_strobe_n)
      else $error("device drives bus outside a read");
   a_no_bus_fight: assert property (
      !(dev_data_oe && host_data_oe))
      else $error("both ends drive the data bus");
   a_width_on_write: assert property (
      $changed(bus_width_indicator) |-> $past(!write_strobe_n)
      || $past(hardware_reset_in) || $past(i_sys_rst))
      else $error("width indicator moved without a write");
   a_strobe_select: assert property (
      !read_strobe_n || !write_strobe_n
      |-> !chip_select_n || !dma_acknowledge_n)
      else $error("strobe without a select");
   a_strobes_apart: assert property (
      read_strobe_n || write_strobe_n)
      else $error("read and write strobes together");
   a_ack_alone: assert property (
      !dma_acknowledge_n |-> chip_select_n)
      else $error("dma acknowledge beside chip select");
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench joining host and device ends of the port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import hostport_pkg::*;
   logic        i_core_clk = 1'b0;
   logic        i_sys_rst  = 1'b1;
   logic [2:0]  h_addr     = 3'h0;
   logic [15:0] h_wdata    = 16'h0000;
   logic        h_wr       = 1'b0;
   logic        h_rd       = 1'b0;
   logic [15:0] h_rdata;
   logic        h_irq;
   logic        mode       = 1'b1;
   logic        pol        = 1'b1;
   logic        rx_valid   = 1'b0;
   logic [15:0] rx_data    = 16'h0000;
   logic        rx_ready;
   logic        tx_valid;
   logic [15:0] tx_data;
   logic        ev         = 1'b0;
   logic [15:0] seed       = 16'hc843;
   logic [15:0] got;
   logic [15:0] exp_tx;
   logic [7:0]  lo_b;
   logic [15:0] rx_words [3];
   logic [15:0] tx_q [$];
   int          err_total  = 0;
   int          cmp_count  = 0;
   int          ri         = 0;
   int          m_ctrl     = 0;

   hostport_if hif ();
   hostport_host u_hostport_host (
      .i_core_clk (i_core_clk), .i_sys_rst (i_sys_rst), .bus (hif),
      .i_addr (h_addr), .i_wdata (h_wdata), .i_wr (h_wr), .i_rd (h_rd),
      .o_rdata (h_rdata), .o_irq (h_irq));
   hostport_device u_hostport_device (
      .i_core_clk (i_core_clk), .i_sys_rst (i_sys_rst), .bus (hif),
      .i_generic_bus_mode_select (mode), .i_ready_polarity_select (pol),
      .i_rx_valid (rx_valid), .i_rx_data (rx_data), .o_rx_ready (rx_ready),
      .o_tx_valid (tx_valid), .o_tx_data (tx_data), .i_event (ev));
   hostport_asserts u_hostport_asserts (
      .i_core_clk (i_core_clk), .i_sys_rst (i_sys_rst),
      .i_generic_bus_mode_select (mode), .i_ready_polarity_select (pol),
      .chip_select_n (hif.chip_select_n),
      .read_strobe_n (hif.read_strobe_n),
      .write_strobe_n (hif.write_strobe_n),
      .dma_acknowledge_n (hif.dma_acknowledge_n),
      .dma_end_of_process (hif.dma_end_of_process),
      .hardware_reset_in (hif.hardware_reset_in),
      .host_data_oe (hif.host_data_oe), .dev_data_oe (hif.dev_data_oe),
      .dma_request (hif.dma_request), .ready (hif.ready),
      .bus_width_indicator (hif.bus_width_indicator));

   always #50 i_core_clk = ~i_core_clk;

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [15:0] mk(input logic [3:0] a,
                                      input logic w, d, hn, l);
      return {8'h00, l, hn, d, w, a};
   endfunction
   task automatic chk16(input logic [15:0] g, e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: word %h, wanted %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: flag %b, wanted %b", $time, g, e);
      end
   endtask
   task automatic complete_run();
      if (err_total == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic hwr(input logic [2:0] a, input logic [15:0] d);
      h_addr  <= a;
      h_wdata <= d;
      h_wr    <= 1'b1;
      @(posedge i_core_clk);
      h_wr    <= 1'b0;
      @(posedge i_core_clk);
   endtask
   task automatic hrd(input logic [2:0] a, output logic [15:0] d);
      h_addr <= a;
      h_rd   <= 1'b1;
      @(posedge i_core_clk);
      h_rd   <= 1'b0;
      #1 d = h_rdata;
      @(posedge i_core_clk);
   endtask
   // one bus cycle through the host sequencer, polled under a bound
   task automatic dcmd(input logic [15:0] c, w, output logic [15:0] r);
      logic [15:0] s;
      hwr(HREG_WDATA, w);
      hwr(HREG_CMD, c);
      s = 16'h8000;
      for (int n = 0; n < 30 && s[15] !== 1'b0; n++) begin
         hrd(HREG_STAT, s);
      end
      chk1(s[15], 1'b0);
      hrd(HREG_RDATA, r);
   endtask
   task automatic dw(input logic [3:0] a, input logic hn,
                     input logic [15:0] d);
      dcmd(mk(a, 1'b1, 1'b0, hn, 1'b0), d, got);
   endtask
   task automatic dr(input logic [3:0] a, input logic hn,
                     output logic [15:0] r);
      dcmd(mk(a, 1'b0, 1'b0, hn, 1'b0), 16'h0000, r);
   endtask
   // status sits at an odd index, so read it in byte mode
   task automatic rd_stat(input logic [7:0] e);
      dw(REG_CTRL, 1'b0, m_ctrl[15:0] | 16'h0020);
      dr(REG_STAT, 1'b0, got);
      chk16({8'h00, got[7:0]}, {8'h00, e});
      dw(REG_CTRL, 1'b0, m_ctrl[15:0]);
   endtask

   always @(negedge i_core_clk) begin
      if (tx_valid === 1'b1) begin
         exp_tx = (tx_q.size() > 0) ? tx_q.pop_front() : ~tx_data;
         chk16(tx_data, exp_tx);
      end
      if (rx_ready === 1'b1) begin
         @(posedge i_core_clk);
         ri       <= ri + 1;
         rx_data  <= rx_words[(ri + 1) % 3];
         rx_valid <= (ri < 2);
      end
   end

   initial begin
      #1000000;
      err_total++;
      complete_run();
   end

   initial begin
      repeat (12) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_core_clk);
      chk1(hif.bus_width_indicator, 1'b1);
      dr(REG_CTRL, 1'b0, got);
      chk16(got, CTRL_RESET);
      dw(REG_CTRL, 1'b1, 16'h4020);
      chk1(hif.bus_width_indicator, 1'b0);
      dr(REG_CTRL, 1'b0, got);
      chk16({8'h00, got[7:0]}, 16'h0020);
      dw(REG_CTRL, 1'b0, 16'h0000);
      chk1(hif.bus_width_indicator, 1'b1);
      dr(REG_CTRL, 1'b0, got);
      chk16(got, CTRL_RESET);
      // event while masked, then unmask through the low lane
      dw(REG_MASK, 1'b0, 16'h0000);
      hwr(HREG_MASK, 16'h0004);
      ev <= 1'b1;
      @(posedge i_core_clk);
      ev <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      chk1(hif.interrupt_n, 1'b1);
      dw(REG_MASK, 1'b1, 16'h0004);
      chk1(hif.interrupt_n, 1'b0);
      chk1(h_irq, 1'b1);
      dr(REG_MASK, 1'b1, got);
      chk16({8'h00, got[7:0]}, 16'h0004);
      rd_stat(8'h04);
      chk1(hif.interrupt_n, 1'b1);
      chk1(h_irq, 1'b0);
      // dma towards the device, both end of process levels, then byte pairs
      for (int p = 0; p < 2; p++) begin
         hwr(HREG_CFG, {13'h0000, 1'b0, p[0], 1'b1});
         m_ctrl = 1 | (p << 2) | (p << 5);
         dw(REG_CTRL, 1'b0, m_ctrl[15:0]);
         chk1(hif.dma_request, 1'b1);
         for (int k = 0; k < 3 + 3 * p; k++) begin
            seed = lfsr(seed);
            if (p == 0 || k[0]) begin
               tx_q.push_back(p ? {seed[7:0], lo_b} : seed);
            end
            lo_b = seed[7:0];
            dcmd(mk(4'h0, 1'b1, 1'b1, 1'b0, k == 2 + 3 * p), seed, got);
         end
         m_ctrl = m_ctrl & ~1;
         chk1(hif.dma_request, 1'b0);
         dr(REG_CTRL, 1'b0, got);
         chk16(got, m_ctrl[15:0]);
         rd_stat(8'h01);
      end
      chk16(16'(tx_q.size()), 16'h0000);
      // dma towards the host with ready active low
      pol <= 1'b0;
      hwr(HREG_CFG, 16'h0000);
      for (int k = 0; k < 3; k++) begin
         seed = lfsr(seed);
         rx_words[k] = seed;
      end
      ri       <= 0;
      rx_data  <= rx_words[0];
      rx_valid <= 1'b1;
      dw(REG_CTRL, 1'b0, 16'h0003);
      chk1(hif.dma_request, 1'b1);
      for (int k = 0; k < 3; k++) begin
         dcmd(mk(4'h0, 1'b0, 1'b1, 1'b0, k == 2), 16'h0000, got);
         chk16(got, rx_words[k]);
      end
      chk1(hif.dma_request, 1'b0);
      chk16(16'(ri), 16'h0003);
      // hardware reset through the host config
      dw(REG_CTRL, 1'b0, 16'h0020);
      hwr(HREG_CFG, 16'h0004);
      repeat (3) @(posedge i_core_clk);
      hwr(HREG_CFG, 16'h0000);
      chk1(hif.bus_width_indicator, 1'b1);
      dr(REG_CTRL, 1'b0, got);
      chk16(got, CTRL_RESET);
      // bus mode off: the cycle hangs until a system reset or the mode select returns
      mode <= 1'b0;
      hwr(HREG_CMD, mk(REG_CTRL, 1'b0, 1'b0, 1'b0, 1'b0));
      repeat (20) @(posedge i_core_clk);
      hrd(HREG_STAT, got);
      chk1(got[15], 1'b1);
      i_sys_rst <= 1'b1;
      pol       <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      mode      <= 1'b1;
      @(posedge i_core_clk);
      dr(REG_CTRL, 1'b0, got);
      chk16(got, CTRL_RESET);
      complete_run();
   end
endmodule
`default_nettype wire
